// *** hdl/cdae_top.sv ***
// Purpose: Walks a host data area and exchanges its items with one component.
// Assumes: Component link logic runs on clk_i and holds ack for one cycle.
// Notes: Area words sit at byte address 4*offset; control and status above them.
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ns
module cdae_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic cmp_req_o,
    output logic cmp_write_o,
    output logic [1:0] cmp_kind_o,
    output logic [4:0] cmp_item_o,
    output logic [31:0] cmp_data_o,
    input wire logic cmp_ack_i,
    input wire logic cmp_err_i,
    input wire logic [15:0] cmp_err_code_i,
    input wire logic [31:0] cmp_rdata_i,
    input wire logic [15:0] cmp_rstatus_i,
    output logic busy_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_REQ} cdae_state_type;

    cdae_state_type state_reg;
    logic [15:0] area_reg [cdae_pkg::AREA_WORDS];
    logic [4:0] ptr_reg;
    logic [1:0] kind_reg;
    logic [2:0] grp_reg;
    logic busy_reg;
    logic done_reg;
    logic err_reg;
    logic [15:0] code_reg;
    logic ack_reg;
    logic bus_req;
    logic bus_wr;
    logic [5:0] bus_idx;
    logic area_hit;
    logic ctrl_wr;
    logic stat_wr;
    logic start_go;
    logic [1:0] new_kind;
    logic [2:0] new_grp;
    logic [15:0] bus_word;
    logic item_sel;
    logic item_pair;
    logic item_status;
    logic [4:0] area_end;
    logic scan_end;
    logic err_ack;
    logic done_set;
    logic job_read;
    logic [4:0] ptr_hi;
    logic [4:0] ptr_st;

    // Bus decode
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign bus_wr = bus_req && wb_we_i;
    assign bus_idx = wb_adr_i[7:2];
    assign area_hit = (wb_adr_i[1:0] == 2'h0) && (bus_idx <= cdae_pkg::AREA_LAST_IDX);
    assign ctrl_wr = bus_wr && (wb_adr_i == cdae_pkg::REG_CTRL);
    assign stat_wr = bus_wr && (wb_adr_i == cdae_pkg::REG_STATUS) && wb_sel_i[0];
    assign bus_word = {wb_sel_i[1] ? wb_dat_i[15:8] : area_reg[bus_idx[4:0]][15:8],
                       wb_sel_i[0] ? wb_dat_i[7:0] : area_reg[bus_idx[4:0]][7:0]};

    // Job start from the control word
    assign new_kind = wb_dat_i[cdae_pkg::CTRL_KIND_LSB +: cdae_pkg::KIND_W];
    assign new_grp = wb_dat_i[cdae_pkg::CTRL_GRP_LSB +: cdae_pkg::GRP_W];
    assign start_go = ctrl_wr && (&wb_sel_i[1:0]) && wb_dat_i[cdae_pkg::CTRL_START_BIT]
        && (state_reg == ST_IDLE) && (new_kind <= cdae_pkg::KIND_PM_READ)
        && (new_grp >= cdae_pkg::GRP_1) && (new_grp <= cdae_pkg::GRP_5);

    // Engine helpers
    assign job_read = (kind_reg == cdae_pkg::KIND_PM_READ);
    assign scan_end = (state_reg == ST_SCAN) && (ptr_reg >= area_end);
    assign err_ack = (state_reg == ST_REQ) && cmp_ack_i && cmp_err_i;
    assign done_set = scan_end || err_ack;
    assign ptr_hi = ptr_reg + cdae_pkg::OFF_HI_WORD;
    assign ptr_st = ptr_reg + cdae_pkg::OFF_STATUS_GAP;

    cdae_item_plan u_plan (
        .kind_i(kind_reg),
        .grp_i(grp_reg),
        .tc_op_i(area_reg[cdae_pkg::OFF_TC_OPCMD]),
        .pm_op_i(area_reg[cdae_pkg::OFF_PM_OPCMD]),
        .off_i(ptr_reg),
        .sel_o(item_sel),
        .pair_o(item_pair),
        .status_o(item_status),
        .area_end_o(area_end)
    );

    // Wishbone answer, one cycle after the request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            ack_reg <= bus_req;
            wb_dat_o <= '0;
            if (area_hit) begin
                wb_dat_o <= {16'h0000, area_reg[bus_idx[4:0]]};
            end else if (wb_adr_i == cdae_pkg::REG_CTRL) begin
                wb_dat_o[cdae_pkg::CTRL_KIND_LSB +: cdae_pkg::KIND_W] <= kind_reg;
                wb_dat_o[cdae_pkg::CTRL_GRP_LSB +: cdae_pkg::GRP_W] <= grp_reg;
            end else if (wb_adr_i == cdae_pkg::REG_STATUS) begin
                wb_dat_o[cdae_pkg::STAT_BUSY_BIT] <= busy_reg;
                wb_dat_o[cdae_pkg::STAT_DONE_BIT] <= done_reg;
                wb_dat_o[cdae_pkg::STAT_ERR_BIT] <= err_reg;
                wb_dat_o[cdae_pkg::STAT_CODE_LSB +: cdae_pkg::WORD_W] <= code_reg;
            end
        end
    end
    assign wb_ack_o = ack_reg;

    // Done flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (done_reg && !(stat_wr && wb_dat_i[cdae_pkg::STAT_DONE_BIT]))
                || done_set;
        end
    end

    // Area words: bus writes while idle, engine results while busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < cdae_pkg::AREA_WORDS; i++) begin
                area_reg[i] <= '0;
            end
        end else begin
            if (bus_wr && area_hit && !busy_reg) begin
                area_reg[bus_idx[4:0]] <= bus_word;
            end
            if (start_go && (new_kind == cdae_pkg::KIND_PM_READ)
                    && (new_grp == cdae_pkg::GRP_4)) begin
                for (int i = cdae_pkg::OFF_PM_CLR_LO; i <= cdae_pkg::OFF_PM_CLR_HI; i++) begin
                    area_reg[i] <= '0;
                end
            end
            if (scan_end) begin
                area_reg[cdae_pkg::OFF_MONITOR] <= cdae_pkg::ERR_NONE;
            end
            if ((state_reg == ST_REQ) && cmp_ack_i) begin
                if (cmp_err_i) begin
                    area_reg[cdae_pkg::OFF_MONITOR] <= cmp_err_code_i;
                    if (job_read) begin
                        area_reg[ptr_reg] <= '0;
                        if (item_pair) area_reg[ptr_hi] <= '0;
                        if (item_status) area_reg[ptr_st] <= '0;
                    end
                end else if (job_read) begin
                    area_reg[ptr_reg] <= cmp_rdata_i[15:0];
                    if (item_pair) area_reg[ptr_hi] <= cmp_rdata_i[31:16];
                    if (item_status) area_reg[ptr_st] <= cmp_rstatus_i;
                end
            end
        end
    end

    // Item walk: idle, scan for next selected item, wait for the component
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_IDLE;
            ptr_reg <= cdae_pkg::OFF_FIRST_ITEM;
            kind_reg <= cdae_pkg::KIND_TC_WRITE;
            grp_reg <= cdae_pkg::GRP_1;
            busy_reg <= 1'b0;
            err_reg <= 1'b0;
            code_reg <= cdae_pkg::ERR_NONE;
            cmp_req_o <= 1'b0;
            cmp_write_o <= 1'b0;
            cmp_kind_o <= cdae_pkg::KIND_TC_WRITE;
            cmp_item_o <= cdae_pkg::OFF_MONITOR;
            cmp_data_o <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start_go) begin
                        kind_reg <= new_kind;
                        grp_reg <= new_grp;
                        ptr_reg <= cdae_pkg::OFF_FIRST_ITEM;
                        busy_reg <= 1'b1;
                        err_reg <= 1'b0;
                        code_reg <= cdae_pkg::ERR_NONE;
                        state_reg <= ST_SCAN;
                    end
                end
                ST_SCAN: begin
                    if (scan_end) begin
                        busy_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (item_sel) begin
                        cmp_req_o <= 1'b1;
                        cmp_write_o <= !job_read;
                        cmp_kind_o <= kind_reg;
                        cmp_item_o <= ptr_reg;
                        // Single words go out sign-extended, pairs low word first
                        cmp_data_o <= job_read ? 32'h0000_0000 :
                            item_pair ? {area_reg[ptr_hi], area_reg[ptr_reg]} :
                            {{16{area_reg[ptr_reg][15]}}, area_reg[ptr_reg]};
                        state_reg <= ST_REQ;
                    end else begin
                        ptr_reg <= ptr_hi;
                    end
                end
                ST_REQ: begin
                    if (cmp_ack_i) begin
                        cmp_req_o <= 1'b0;
                        if (cmp_err_i) begin
                            err_reg <= 1'b1;
                            code_reg <= cmp_err_code_i;
                            busy_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else begin
                            ptr_reg <= item_pair ? ptr_st : ptr_hi;
                            state_reg <= ST_SCAN;
                        end
                    end
                end
            endcase
        end
    end
    assign busy_o = busy_reg;

    // Checks
    sequence s_err_ack;
        (state_reg == ST_REQ) && cmp_ack_i && cmp_err_i;
    endsequence
    sequence s_quiet;
        !cmp_req_o && !busy_reg;
    endsequence

    a_err_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        s_err_ack |=> s_quiet [*2]) else $error("error did not end the job");
    a_err_monitor: assert property (@(posedge clk_i) disable iff (rst_i)
        s_err_ack |=> area_reg[0] == $past(cmp_err_code_i)) else $error("monitor lacks code");
    a_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        s_err_ack ##0 job_read |=> area_reg[$past(ptr_reg)] == 16'h0000)
        else $error("read error left data");
    a_walk_order: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_reg && $past(busy_reg) |-> ptr_reg >= $past(ptr_reg)) else $error("walk went back");
    a_req_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_req_o && !cmp_ack_i |=> cmp_req_o && $stable(cmp_item_o) && $stable(cmp_data_o))
        else $error("request dropped early");
    a_area_extent: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_req_o |-> cmp_item_o < area_end) else $error("item past area end");
    a_autotune_only: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(cmp_req_o) && (kind_reg == cdae_pkg::KIND_TC_WRITE) && (grp_reg >= cdae_pkg::GRP_2)
        && (area_reg[cdae_pkg::OFF_TC_OPCMD] == cdae_pkg::TC_OP_AT_START)
        |-> cmp_item_o == cdae_pkg::OFF_TC_OPCMD) else $error("setting sent with tune start");
    a_opcmd_group: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_req_o && (cmp_kind_o == cdae_pkg::KIND_TC_WRITE)
        && (cmp_item_o == cdae_pkg::OFF_TC_OPCMD) |-> grp_reg >= cdae_pkg::GRP_2)
        else $error("command outside its group");
    a_pm_group: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_req_o && (cmp_kind_o == cdae_pkg::KIND_PM_WRITE)
        |-> grp_reg >= cdae_pkg::GRP_3) else $error("meter write in groups 1 or 2");
    a_group_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        start_go && (new_kind == cdae_pkg::KIND_PM_READ) && (new_grp == cdae_pkg::GRP_4)
        |=> area_reg[4] == 16'h0000 && area_reg[9] == 16'h0000) else $error("hold words kept");
    a_untouched: assert property (@(posedge clk_i) disable iff (rst_i)
        busy_reg && !job_read |=> $stable(area_reg[8])) else $error("write job changed data");
endmodule : cdae_top

// *** hdl/cdae_pkg.sv ***
// Purpose: Shared constants for the component data area exchange block.
// Assumes: 16-bit host words, 32-bit Wishbone data, byte address = 4 * word index.
// Notes: Area offsets are word indexes inside the one area buffer.
package cdae_pkg;
    localparam int WORD_W = 16;
    localparam int DATA_W = 32;
    localparam int ADR_W = 8;
    localparam int OFF_W = 5;
    localparam int GRP_W = 3;
    localparam int KIND_W = 2;
    localparam int AREA_WORDS = 18;

    // Job kinds
    localparam logic [1:0] KIND_TC_WRITE = 2'h0;
    localparam logic [1:0] KIND_PM_WRITE = 2'h1;
    localparam logic [1:0] KIND_PM_READ = 2'h2;

    // Area lengths in words
    localparam logic [4:0] TC_WRITE_WORDS = 5'h09;
    localparam logic [4:0] PM_WRITE_WORDS = 5'h0a;
    localparam logic [4:0] PM_READ_WORDS = 5'h12;

    // Word offsets
    localparam logic [4:0] OFF_MONITOR = 5'h00;
    localparam logic [4:0] OFF_FIRST_ITEM = 5'h01;
    localparam logic [4:0] OFF_TC_TARGET = 5'h01;
    localparam logic [4:0] OFF_TC_OPCMD = 5'h02;
    localparam logic [4:0] OFF_TC_ALARM1 = 5'h03;
    localparam logic [4:0] OFF_TC_ALARM2 = 5'h04;
    localparam logic [4:0] OFF_TC_PBAND = 5'h05;
    localparam logic [4:0] OFF_TC_INTEG = 5'h06;
    localparam logic [4:0] OFF_TC_DERIV = 5'h07;
    localparam logic [4:0] OFF_TC_HEATER = 5'h08;
    localparam logic [4:0] OFF_PM_OPCMD = 5'h01;
    localparam logic [4:0] OFF_PM_LIMIT0 = 5'h02;
    localparam logic [4:0] OFF_PM_DISPLAY = 5'h01;
    localparam logic [4:0] OFF_PM_PEAK = 5'h04;
    localparam logic [4:0] OFF_PM_BOTTOM = 5'h07;
    localparam logic [4:0] OFF_PM_CMP0 = 5'h0a;
    localparam logic [4:0] OFF_PM_CLR_LO = 5'h04;
    localparam logic [4:0] OFF_PM_CLR_HI = 5'h09;
    localparam logic [4:0] OFF_HI_WORD = 5'h01;
    localparam logic [4:0] OFF_STATUS_GAP = 5'h02;

    // Command groups
    localparam logic [2:0] GRP_1 = 3'h1;
    localparam logic [2:0] GRP_2 = 3'h2;
    localparam logic [2:0] GRP_3 = 3'h3;
    localparam logic [2:0] GRP_4 = 3'h4;
    localparam logic [2:0] GRP_5 = 3'h5;

    // Operation codes
    localparam logic [15:0] OP_NONE = 16'h0000;
    localparam logic [15:0] TC_OP_AT_STOP = 16'h0001;
    localparam logic [15:0] TC_OP_AT_START = 16'h0002;
    localparam logic [15:0] TC_OP_BACKUP = 16'h0003;
    localparam logic [15:0] TC_OP_RAM = 16'h0004;
    localparam logic [15:0] TC_OP_SAVE = 16'h0005;
    localparam logic [15:0] PM_OP_RESET = 16'h0001;
    localparam logic [15:0] PM_OP_BACKUP = 16'h0002;
    localparam logic [15:0] PM_OP_RAM = 16'h0003;
    localparam logic [15:0] PM_OP_SAVE = 16'h0004;
    localparam logic [15:0] ERR_NONE = 16'h0000;

    // Register map (last area word index, then byte addresses)
    localparam logic [5:0] AREA_LAST_IDX = 6'h11;
    localparam logic [7:0] REG_CTRL = 8'h80;
    localparam logic [7:0] REG_STATUS = 8'h84;

    // Control fields
    localparam int CTRL_GRP_LSB = 0;
    localparam int CTRL_KIND_LSB = 4;
    localparam int CTRL_START_BIT = 8;

    // Status fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_CODE_LSB = 16;
endpackage : cdae_pkg

// *** hdl/cdae_item_plan.sv ***
// Purpose: Decides whether an area offset starts an item for the current job.
// Assumes: Offset walks upward from the first item word.
// Notes: Purely combinational; the caller registers what leaves the block.
`timescale 1ns/1ns
module cdae_item_plan (
    input wire logic [1:0] kind_i,
    input wire logic [2:0] grp_i,
    input wire logic [15:0] tc_op_i,
    input wire logic [15:0] pm_op_i,
    input wire logic [4:0] off_i,
    output logic sel_o,
    output logic pair_o,
    output logic status_o,
    output logic [4:0] area_end_o
);
    logic tc_at_block;
    logic pm_hold_grp;

    // Start auto-tuning in this scan blocks every setting value
    assign tc_at_block = (grp_i >= cdae_pkg::GRP_2) && (tc_op_i == cdae_pkg::TC_OP_AT_START);
    assign pm_hold_grp = (grp_i == cdae_pkg::GRP_2) || (grp_i == cdae_pkg::GRP_3)
        || (grp_i == cdae_pkg::GRP_5);

    // Item table per job kind
    always_comb begin
        sel_o = 1'b0;
        pair_o = 1'b0;
        status_o = 1'b0;
        area_end_o = cdae_pkg::TC_WRITE_WORDS;
        unique case (kind_i)
            cdae_pkg::KIND_TC_WRITE: begin
                area_end_o = cdae_pkg::TC_WRITE_WORDS;
                unique case (off_i)
                    cdae_pkg::OFF_TC_TARGET: sel_o = !tc_at_block;
                    cdae_pkg::OFF_TC_OPCMD: sel_o = (grp_i >= cdae_pkg::GRP_2)
                        && (tc_op_i != cdae_pkg::OP_NONE)
                        && (tc_op_i <= cdae_pkg::TC_OP_SAVE);
                    cdae_pkg::OFF_TC_ALARM1,
                    cdae_pkg::OFF_TC_ALARM2: sel_o = (grp_i >= cdae_pkg::GRP_3) && !tc_at_block;
                    cdae_pkg::OFF_TC_PBAND,
                    cdae_pkg::OFF_TC_INTEG,
                    cdae_pkg::OFF_TC_DERIV: sel_o = (grp_i >= cdae_pkg::GRP_4) && !tc_at_block;
                    cdae_pkg::OFF_TC_HEATER: sel_o = (grp_i == cdae_pkg::GRP_5) && !tc_at_block;
                    default: sel_o = 1'b0;
                endcase
            end
            cdae_pkg::KIND_PM_WRITE: begin
                area_end_o = cdae_pkg::PM_WRITE_WORDS;
                if (off_i == cdae_pkg::OFF_PM_OPCMD) begin
                    sel_o = ((grp_i == cdae_pkg::GRP_3) || (grp_i == cdae_pkg::GRP_5))
                        && (pm_op_i != cdae_pkg::OP_NONE)
                        && (pm_op_i <= cdae_pkg::PM_OP_SAVE);
                end else if ((off_i >= cdae_pkg::OFF_PM_LIMIT0) && !off_i[0]) begin
                    sel_o = (grp_i >= cdae_pkg::GRP_4);
                    pair_o = 1'b1;
                end
            end
            default: begin
                area_end_o = cdae_pkg::PM_READ_WORDS;
                if (off_i == cdae_pkg::OFF_PM_DISPLAY) begin
                    sel_o = 1'b1;
                    pair_o = 1'b1;
                    status_o = 1'b1;
                end else if ((off_i == cdae_pkg::OFF_PM_PEAK)
                        || (off_i == cdae_pkg::OFF_PM_BOTTOM)) begin
                    sel_o = pm_hold_grp;
                    pair_o = 1'b1;
                    status_o = 1'b1;
                end else if ((off_i >= cdae_pkg::OFF_PM_CMP0) && !off_i[0]) begin
                    sel_o = (grp_i >= cdae_pkg::GRP_4);
                    pair_o = 1'b1;
                end
            end
        endcase
    end
endmodule : cdae_item_plan

// *** testbench/cdae_partner.sv ***
// Purpose: Component model answering item requests of the exchange block.
// Assumes: One request outstanding at a time; ack is a one-cycle pulse.
// Notes: Answer lines toggle outside the answer cycle, never hold old data.
`timescale 1ns/1ns
module cdae_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic [4:0] item_i,
    input wire logic [4:0] err_item_i,
    input wire logic [1:0] dly_i,
    output logic ack_o = 1'b0,
    output logic err_o = 1'b0,
    output logic [15:0] code_o = 16'h0000,
    output logic [31:0] rdata_o = 32'h0,
    output logic [15:0] rstat_o = 16'h0000
);
    logic [1:0] wait_reg = 2'h0;
    logic fire;
    // Answer once dly_i idle cycles have passed
    assign fire = req_i && !ack_o && !rst_i && wait_reg == dly_i;
    always @(posedge clk_i) begin
        if (rst_i || ack_o) begin
            ack_o <= 1'b0;
            wait_reg <= 2'h0;
        end else if (fire) begin
            ack_o <= 1'b1;
        end else if (req_i) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
    // Answer fields, fail on the chosen item
    always @(posedge clk_i) begin
        if (fire) begin
            err_o <= item_i == err_item_i;
            code_o <= {11'h050, item_i};
            rdata_o <= {11'h7ff, item_i, 11'h000, item_i};
            rstat_o <= {11'h004, item_i};
        end else begin
            err_o <= ~err_o;
            code_o <= ~code_o;
            rdata_o <= ~rdata_o;
            rstat_o <= ~rstat_o;
        end
    end
endmodule : cdae_partner

// *** testbench/test_component_data_area_exchange.sv ***
// Purpose: Self-checking bench for the data area exchange block.
// Assumes: Partner model answers with a random delay per job.
// Notes: Item stream is predicted by a queue model, area contents by a word array.
`timescale 1ns/1ns
module test_component_data_area_exchange;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_sel = 4'hf;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_rd, wb_q, data, rdata;
    logic wb_ack, req, wr, ack, err, busy;
    logic [1:0] kind;
    logic [1:0] dly = 2'h0;
    logic [4:0] item;
    logic [4:0] err_item = 5'h00;
    logic [15:0] code, rstat;
    logic [39:0] exp_q[$];
    logic [15:0] mem[18];
    int errors = 0;
    int check_count = 0;
    int seed = 18;

    // Clock
    always #25 clk_i = ~clk_i;

    cdae_top cdae_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .cmp_req_o(req), .cmp_write_o(wr),
        .cmp_kind_o(kind), .cmp_item_o(item), .cmp_data_o(data), .cmp_ack_i(ack),
        .cmp_err_i(err), .cmp_err_code_i(code), .cmp_rdata_i(rdata),
        .cmp_rstatus_i(rstat), .busy_o(busy));
    cdae_partner cdae_partner_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .item_i(item),
        .err_item_i(err_item), .dly_i(dly), .ack_o(ack), .err_o(err), .code_o(code),
        .rdata_o(rdata), .rstat_o(rstat));

    task automatic complete_run;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        wb_q = wb_rd;
        wb_cyc <= 1'b0;
        if (n == 20) begin
            errors++;
            complete_run();
        end
    endtask : wb

    function automatic bit pick(int k, int g, int op, int o);
        bit at;
        at = k == 0 && g >= 2 && op == 2;
        if (k == 0)
            return o == 2 ? g >= 2 && op >= 1 && op <= 5 : !at && (o == 1
                || (o <= 4 && g >= 3) || (o <= 7 && g >= 4) || (o == 8 && g == 5));
        if (k == 1)
            return o == 1 ? (g == 3 || g == 5) && op >= 1 && op <= 4 : o % 2 == 0 && o <= 8 && g >= 4;
        return o == 1 || ((o == 4 || o == 7) && g != 1 && g != 4) || (o >= 10 && o % 2 == 0 && g >= 4);
    endfunction : pick

    task automatic job(input int k, input int g, input int op, input int e);
        int n = 0;
        bit ab = 0;
        logic [31:0] v;
        // Host fills the area, any signed values
        for (int o = 0; o < 18; o++) begin
            mem[o] = 16'($random(seed));
            if (o == 2 - k)
                mem[o] = 16'(op);
            wb(1'b1, 8'(o * 4), {16'h0, mem[o]});
        end
        for (int o = 4; o < 10; o++)
            if (k == 2 && g == 4)
                mem[o] = 16'h0;
        // Predict item stream and final area
        for (int o = 1; o < 18; o++) begin
            if (!ab && pick(k, g, op, o)) begin
                v = k == 2 ? 32'h0 : (k == 1 && o > 1) ? {mem[o + 1], mem[o]} : {{16{mem[o][15]}}, mem[o]};
                exp_q.push_back({2'(k), k != 2, 5'(o), v});
                ab = o == e;
                if (ab)
                    mem[0] = {11'h050, 5'(o)};
                if (k == 2)
                    {mem[o + 1], mem[o]} = ab ? 32'h0 : {11'h7ff, 5'(o), 11'h000, 5'(o)};
                if (k == 2 && o < 10)
                    mem[o + 2] = ab ? 16'h0 : {11'h004, 5'(o)};
            end
        end
        if (!ab)
            mem[0] = 16'h0;
        err_item <= 5'(e);
        dly <= 2'($random(seed));
        wb(1'b1, 8'h80, {23'h0, 1'b1, 2'h0, 2'(k), 1'b0, 3'(g)});
        wb(1'b1, 8'h44, 32'h5a5a);
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        check(40'(exp_q.size()) + 40'(n == 300), 40'h0);
        if (n == 300)
            complete_run();
        exp_q.delete();
        wb(1'b0, 8'h84, 32'h0);
        check(ab ? wb_q : {16'h0, wb_q[15:0]}, {mem[0], 13'h0, ab, 2'h2});
        wb(1'b1, 8'h84, 32'h2);
        // Done cleared, error kept, control shows the latched job
        wb(1'b0, 8'h84, 32'h0);
        check(wb_q[2:0], {37'h0, ab, 2'h0});
        wb(1'b0, 8'h80, 32'h0);
        check(wb_q, {26'h0, 2'(k), 1'b0, 3'(g)});
        for (int o = 0; o < 18; o++) begin
            wb(1'b0, 8'(o * 4), 32'h0);
            check(wb_q, {16'h0, mem[o]});
        end
    endtask : job

    // Each accepted item must be the next predicted one
    always @(posedge clk_i) begin
        if (!rst_i && req === 1'b1 && ack === 1'b1)
            check({kind, wr, item, data}, exp_q.size() > 0 ? exp_q.pop_front() : 40'hx);
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int o = 0; o < 19; o++) begin
            wb(1'b0, 8'(o * 4), 32'h0);
            check(wb_q, 40'h0);
        end
        // Starts with a bad group or kind are ignored
        for (int b = 0; b < 3; b++) begin
            wb(1'b1, 8'h80, b == 0 ? 32'h100 : b == 1 ? 32'h131 : 32'h106);
            check(busy, 40'h0);
        end
        // Each kind, group and command code 0 to 5 runs once, some jobs failing on an item
        for (int j = 0; j < 90; j++)
            job(j % 3, 1 + (j / 3) % 5, (j / 3) % 6,
                j % 4 == 1 ? 1 : j % 4 == 2 ? 1 + int'($unsigned($random(seed)) % 17) : 0);
        complete_run();
    end
endmodule : test_component_data_area_exchange
